// ==== design/scirq_top.sv ====
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// - four requests tx ready, rx ready, tx event, rx event; status and enable zero.
// - each event source is ANDed with its own enable bit.
// - event summary status bits ignore their summary enables.
// - tx ready clears at count of threshold plus one or transmitter off.
// - channel or tx reset clears tx ready and all tx events.
// - rx ready clears when receive buffer is empty or on resets.
// - channel or rx reset clears every rx event source.
// - tx summary ORs enabled underrun, idle and cts change.
// - writing one clears an event status bit, tx idle excepted; zero leaves it.
// - tx idle clears when host writes transmit data.
// - rx summary ORs twelve enabled receive event sources.
// - bit sync frame end read copies live frame bits to saved, resets live ones except parity/mp.
// - parity/mp clears on next byte zero in mode one, else two.
// - with crc check on, crc error follows running result, clears itself.
// - each request is its status ANDed with its enable.
// - channel reset clears all status and all enable bits.
module scirq_top
  import scirq_pkg::*;
#(
  parameter int CW = 6
)(
  // clock and channel reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // avalon-mm slave
  input  wire logic [5:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  // channel commands
  input  wire logic          chan_reset_cmd,
  input  wire logic          tx_reset_cmd,
  input  wire logic          rx_reset_cmd,
  // transmitter side
  input  wire logic          tx_enable,
  input  wire logic [CW-1:0] tx_count,
  input  wire logic          tx_data_write,
  input  wire logic          tx_underrun,
  input  wire logic          tx_idle_enter,
  // modem pins
  input  wire logic          cts_pin_n,
  input  wire logic          dcd_pin_n,
  // receiver side
  input  wire logic          rx_empty,
  input  wire logic          rx_data_read,
  input  wire logic          rx_read_last,
  input  wire logic          rx_head_valid,
  input  wire logic          rx_head_pmp,
  input  wire logic          rx_next_valid,
  input  wire logic          rx_next_pmp,
  input  wire logic [11:0]   rx_src_set,
  input  wire logic          crc_result_bad,
  // requests
  output logic               tx_ready_req,
  output logic               rx_ready_req,
  output logic               tx_event_req,
  output logic               rx_event_req,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////
  // declarations

  logic                  ack_reg;
  logic [31:0]           rd_reg;
  logic [31:0]           rd_next;
  logic                  wr_take;
  logic [3:0]            wr_index;
  logic [7:0]            enable_reg;
  logic [TX_SRC_NUM-1:0] tx_en_reg;
  logic [RX_SRC_NUM-1:0] rx_en_reg;
  logic [CW-1:0]         tx_thr_reg;
  logic [MODE_W-1:0]     mode_reg;
  logic [FRAME_W-1:0]    frame_saved_reg;
  logic                  tx_ready_reg;
  logic                  rx_ready_reg;
  logic [2:0]            cts_sync_reg;
  logic [2:0]            dcd_sync_reg;
  logic                  chan_clr;
  logic                  tx_clr;
  logic                  rx_clr;
  logic                  frame_copy;
  logic                  pmp_auto;
  logic                  crc_check;
  logic [TX_SRC_NUM-1:0] tx_set;
  logic [TX_SRC_NUM-1:0] tx_soft;
  logic [TX_SRC_NUM-1:0] tx_stat;
  logic [RX_SRC_NUM-1:0] rx_set;
  logic [RX_SRC_NUM-1:0] rx_soft;
  logic [RX_SRC_NUM-1:0] rx_stat;
  logic [RX_SRC_NUM-1:0] rx_w1c;
  logic                  tx_summary;
  logic                  rx_summary;
  logic [7:0]            status_zero;

  ////////////////////////////////////////////////////////////////
  // avalon slave: one wait state on every access

  // ack rises one cycle after the request and drops again at the next edge, whether or not the request stays
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_take         = avs_write & ack_reg;
  assign wr_index        = avs_address[5:2];

  // read data captured in the wait cycle, so it stands at the ack edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_reg <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      rd_reg <= rd_next;
    end
  end

  assign avs_readdata = rd_reg;

  // read mux; unmapped words read as zero
  always_comb begin
    rd_next = 32'h0;
    case (wr_index)
      OFF_STATUS_ZERO[5:2]: rd_next[7:0] = status_zero;
      OFF_ENABLE_ZERO[5:2]: rd_next[7:0] = enable_reg;
      OFF_TX_EV_STAT[5:2]:  rd_next[TX_SRC_NUM-1:0] = tx_stat;
      OFF_TX_EV_EN[5:2]:    rd_next[TX_SRC_NUM-1:0] = tx_en_reg;
      OFF_RX_EV_STAT[5:2]:  rd_next[RX_SRC_NUM-1:0] = rx_stat;
      OFF_RX_EV_EN[5:2]:    rd_next[RX_SRC_NUM-1:0] = rx_en_reg;
      OFF_FRAME_LIVE[5:2]:  rd_next[FRAME_W-1:0] = rx_stat[FRAME_HI:FRAME_LO];
      OFF_FRAME_SAVED[5:2]: rd_next[FRAME_W-1:0] = frame_saved_reg;
      OFF_TX_THRESH[5:2]:   rd_next[CW-1:0] = tx_thr_reg;
      OFF_MODE_ZERO[5:2]:   rd_next[MODE_W-1:0] = mode_reg;
      default:              rd_next = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // clear terms

  assign chan_clr   = chan_reset_cmd;
  assign tx_clr     = chan_clr | tx_reset_cmd;
  assign rx_clr     = chan_clr | rx_reset_cmd;
  assign crc_check  = mode_reg[MODE_CRC_CHK];

  // frame end: last byte of a completed frame leaves the buffer
  assign frame_copy = mode_reg[MODE_BIT_SYNC] & rx_data_read & rx_read_last;

  // mode one looks at one byte ahead, the others need two clean bytes
  always_comb begin
    if (mode_reg[MODE_HOST_HI:MODE_HOST_LO] == HOST_MODE_ONE) begin
      pmp_auto = rx_head_valid & ~rx_head_pmp;
    end else begin
      pmp_auto = rx_head_valid & ~rx_head_pmp & rx_next_valid & ~rx_next_pmp;
    end
  end

  ////////////////////////////////////////////////////////////////
  // software writable registers

  // enables and control fields; a channel reset zeroes the enables
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chan_clr) begin
      enable_reg <= RST_ENABLE_ZERO;
      tx_en_reg  <= '0;
      rx_en_reg  <= '0;
    end else if (wr_take) begin
      if (wr_index == OFF_ENABLE_ZERO[5:2]) begin
        enable_reg <= avs_writedata[7:0];
      end
      if (wr_index == OFF_TX_EV_EN[5:2]) begin
        tx_en_reg <= avs_writedata[TX_SRC_NUM-1:0];
      end
      if (wr_index == OFF_RX_EV_EN[5:2]) begin
        rx_en_reg <= avs_writedata[RX_SRC_NUM-1:0];
      end
    end
  end

  // threshold and mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chan_clr) begin
      tx_thr_reg <= '0;
      mode_reg   <= RST_MODE;
    end else if (wr_take) begin
      if (wr_index == OFF_TX_THRESH[5:2]) begin
        tx_thr_reg <= avs_writedata[CW-1:0];
      end
      if (wr_index == OFF_MODE_ZERO[5:2]) begin
        mode_reg <= avs_writedata[MODE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // ready conditions

  // tx ready holds only while count is at most the threshold
  always_ff @(posedge sys_clk) begin
    if (!rst_n || tx_clr) begin
      tx_ready_reg <= 1'b0;
    end else begin
      tx_ready_reg <= tx_enable & (tx_count <= tx_thr_reg);
    end
  end

  // rx ready follows buffer occupancy
  always_ff @(posedge sys_clk) begin
    if (!rst_n || rx_clr) begin
      rx_ready_reg <= 1'b0;
    end else begin
      rx_ready_reg <= ~rx_empty;
    end
  end

  ////////////////////////////////////////////////////////////////
  // modem pin synchronisers; the first stage feeds only the second

  // reset to the idle high level of the pins, so no false change follows reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cts_sync_reg <= 3'h7;
      dcd_sync_reg <= 3'h7;
    end else begin
      cts_sync_reg <= {cts_sync_reg[1:0], cts_pin_n};
      dcd_sync_reg <= {dcd_sync_reg[1:0], dcd_pin_n};
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit event sources

  // set and soft clear per source; idle drops on a data write
  always_comb begin
    tx_set                = '0;
    tx_set[TX_UNDERRUN]   = tx_underrun;
    tx_set[TX_IDLE]       = tx_idle_enter;
    tx_set[TX_CTS_CHANGE] = cts_sync_reg[2] ^ cts_sync_reg[1];
    tx_soft               = '0;
    if (wr_take && wr_index == OFF_TX_EV_STAT[5:2]) begin
      tx_soft = avs_writedata[TX_SRC_NUM-1:0] & TX_W1C_MASK;
    end
    tx_soft[TX_IDLE] = tx_data_write;
  end

  genvar gi;
  generate
    for (gi = 0; gi < TX_SRC_NUM; gi++) begin : g_tx
      scirq_event_bit u_bit (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .set_evt  (tx_set[gi]),
        .soft_clr (tx_soft[gi]),
        .hard_clr (tx_clr),
        .flag     (tx_stat[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // receive event sources

  assign rx_w1c = (wr_take && wr_index == OFF_RX_EV_STAT[5:2]) ?
                  avs_writedata[RX_SRC_NUM-1:0] : '0;

  // sets come from the receiver, plus dcd edges and the saved frame end
  always_comb begin
    rx_set                = rx_src_set;
    rx_set[RX_DCD_CHANGE] = dcd_sync_reg[2] ^ dcd_sync_reg[1];
    rx_set[RX_FST_END]    = frame_copy & rx_stat[RX_FRAME_END];
    rx_soft               = rx_w1c;
    // live frame bits other than parity/mp empty once copied out
    if (frame_copy) begin
      rx_soft[FRAME_HI:FRAME_LO] = '1;
    end
    rx_soft[RX_PARITY_MP] = rx_w1c[RX_PARITY_MP] | pmp_auto;
    // crc check mode: the bit tracks the running result, one cycle late
    if (crc_check) begin
      rx_set[RX_CRC_ERR]  = crc_result_bad;
      rx_soft[RX_CRC_ERR] = ~crc_result_bad;
    end
  end

  generate
    for (gi = 0; gi < RX_SRC_NUM; gi++) begin : g_rx
      scirq_event_bit u_bit (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .set_evt  (rx_set[gi]),
        .soft_clr (rx_soft[gi]),
        .hard_clr (rx_clr),
        .flag     (rx_stat[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // saved frame status

  // snapshot taken before the live bits are wiped
  always_ff @(posedge sys_clk) begin
    if (!rst_n || rx_clr) begin
      frame_saved_reg <= '0;
    end else if (frame_copy) begin
      frame_saved_reg <= rx_stat[FRAME_HI:FRAME_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // summaries and requests

  // per-source gating before the OR
  assign tx_summary = |(tx_stat & tx_en_reg);
  assign rx_summary = |(rx_stat & rx_en_reg);

  // summary bits show regardless of their own enables
  always_comb begin
    status_zero              = 8'h00;
    status_zero[ST_TX_EVENT] = tx_summary;
    status_zero[ST_RX_EVENT] = rx_summary;
    status_zero[ST_TX_READY] = tx_ready_reg;
    status_zero[ST_RX_READY] = rx_ready_reg;
  end

  // combinational levels: they fall as soon as the cause goes
  assign tx_ready_req = status_zero[ST_TX_READY] & enable_reg[ST_TX_READY];
  assign rx_ready_req = status_zero[ST_RX_READY] & enable_reg[ST_RX_READY];
  assign tx_event_req = status_zero[ST_TX_EVENT] & enable_reg[ST_TX_EVENT];
  assign rx_event_req = status_zero[ST_RX_EVENT] & enable_reg[ST_RX_EVENT];

  // single line toward the processor
  assign irq = tx_ready_req | rx_ready_req | tx_event_req | rx_event_req;

endmodule

// ==== design/scirq_pkg.sv ====
package scirq_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_STATUS_ZERO  = 6'h00;
  localparam logic [5:0] OFF_ENABLE_ZERO  = 6'h04;
  localparam logic [5:0] OFF_TX_EV_STAT   = 6'h08;
  localparam logic [5:0] OFF_TX_EV_EN     = 6'h0C;
  localparam logic [5:0] OFF_RX_EV_STAT   = 6'h10;
  localparam logic [5:0] OFF_RX_EV_EN     = 6'h14;
  localparam logic [5:0] OFF_FRAME_LIVE   = 6'h18;
  localparam logic [5:0] OFF_FRAME_SAVED  = 6'h1C;
  localparam logic [5:0] OFF_TX_THRESH    = 6'h20;
  localparam logic [5:0] OFF_MODE_ZERO    = 6'h24;

  // status_reg_zero and irq_enable_reg_zero bit positions
  localparam int ST_TX_EVENT = 7;
  localparam int ST_RX_EVENT = 6;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_READY = 0;

  // transmit event sources
  localparam int TX_SRC_NUM    = 3;
  localparam int TX_UNDERRUN   = 0;
  localparam int TX_IDLE       = 1;
  localparam int TX_CTS_CHANGE = 2;
  localparam logic [TX_SRC_NUM-1:0] TX_W1C_MASK = 3'h5;

  // receive event sources
  localparam int RX_SRC_NUM    = 12;
  localparam int RX_SYNC_FLAG  = 0;
  localparam int RX_DCD_CHANGE = 1;
  localparam int RX_BRK_ABORT  = 2;
  localparam int RX_BRK_END    = 3;
  localparam int RX_FRAME_END  = 4;
  localparam int RX_PARITY_MP  = 5;
  localparam int RX_PE_ABORT   = 6;
  localparam int RX_FRAMING    = 7;
  localparam int RX_OVERRUN    = 8;
  localparam int RX_CRC_ERR    = 9;
  localparam int RX_FST_END    = 10;
  localparam int RX_CLK_MISS   = 11;

  // frame-specific bits: rx sources FRAME_END up to CRC_ERR
  localparam int FRAME_LO = 4;
  localparam int FRAME_HI = 9;
  localparam int FRAME_W  = FRAME_HI - FRAME_LO + 1;

  // mode_reg_zero field positions
  localparam int MODE_HOST_LO  = 0;
  localparam int MODE_HOST_HI  = 1;
  localparam int MODE_BIT_SYNC = 2;
  localparam int MODE_CRC_CHK  = 3;
  localparam int MODE_W        = 4;
  localparam logic [1:0] HOST_MODE_ONE = 2'h1;

  // reset values
  localparam logic [7:0] RST_ENABLE_ZERO = 8'h00;
  localparam logic [MODE_W-1:0] RST_MODE = 4'h0;

endpackage

// ==== design/scirq_event_bit.sv ====
`timescale 1ns/1ps
// one sticky interrupt source flag
module scirq_event_bit
  import scirq_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // set and clear terms
  input  wire logic set_evt,
  input  wire logic soft_clr,
  input  wire logic hard_clr,
  // flag
  output logic      flag
);

  logic flag_reg;

  // a set arriving with a soft clear survives; reset commands win outright
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (hard_clr) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= set_evt | (flag_reg & ~soft_clr);
    end
  end

  assign flag = flag_reg;

endmodule

// ==== tb/scirq_assertions.sv ====
`timescale 1ns/1ps
// protocol and request checks on the top ports
module scirq_checker
  import scirq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // commands and sources
  input wire logic chan_reset_cmd,
  input wire logic tx_reset_cmd,
  input wire logic rx_reset_cmd,
  input wire logic tx_enable,
  input wire logic tx_data_write,
  input wire logic rx_empty,
  // requests
  input wire logic tx_ready_req,
  input wire logic rx_ready_req,
  input wire logic tx_event_req,
  input wire logic rx_event_req,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // requests are plain levels, so every relation holds cycle by cycle
  irq_or_a: assert property (irq == (tx_ready_req | rx_ready_req | tx_event_req | rx_event_req))
    else $error("irq differs from the four requests");
  wait_first_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait state on new access");
  one_wait_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  rx_empty_a: assert property (rx_empty [*2] |-> !rx_ready_req)
    else $error("rx ready stays with empty buffer");
  rx_cause_a: assert property (rx_ready_req |-> !$past(rx_empty))
    else $error("rx ready without data");
  tx_off_a: assert property (!tx_enable |=> !tx_ready_req)
    else $error("tx ready with transmitter off");
  tx_cause_a: assert property (tx_ready_req |-> $past(tx_enable))
    else $error("tx ready without transmitter on");
  chan_reset_a: assert property (chan_reset_cmd |=> !irq)
    else $error("request after channel reset");
  tx_reset_a: assert property (tx_reset_cmd |=> !tx_event_req && !tx_ready_req)
    else $error("tx request after tx reset");
  rx_reset_a: assert property (rx_reset_cmd |=> !rx_event_req && !rx_ready_req)
    else $error("rx request after rx reset");
  tx_fall_a: assert property ($fell(tx_event_req) |-> $past(avs_write | tx_data_write | tx_reset_cmd | chan_reset_cmd))
    else $error("tx event dropped without cause");
endmodule

bind scirq_top scirq_checker u_scirq_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .chan_reset_cmd(chan_reset_cmd), .tx_reset_cmd(tx_reset_cmd),
  .rx_reset_cmd(rx_reset_cmd), .tx_enable(tx_enable), .tx_data_write(tx_data_write), .rx_empty(rx_empty),
  .tx_ready_req(tx_ready_req), .rx_ready_req(rx_ready_req), .tx_event_req(tx_event_req),
  .rx_event_req(rx_event_req), .irq(irq)
);

// ==== tb/scirq_host_model.sv ====
`timescale 1ns/1ps
// avalon master standing in for the host processor
module scirq_host_model
  import scirq_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // avalon-mm master
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // one access held until waitrequest is sampled low at a rising edge; data taken and request
  // dropped at that edge; an idle edge passes before the next access; data inverted after
  task acc(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d;
  endtask
endmodule

// ==== tb/scirq_top_tb.sv ====
`timescale 1ns/1ps
module scirq_top_tb;
  import scirq_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic        chan_reset_cmd = 1'b0, tx_reset_cmd = 1'b0, rx_reset_cmd = 1'b0;
  logic        tx_enable = 1'b0, tx_data_write = 1'b0, tx_underrun = 1'b0, tx_idle_enter = 1'b0;
  logic [5:0]  tx_count = 6'h00;
  logic        cts_pin_n = 1'b1, dcd_pin_n = 1'b1, crc_result_bad = 1'b0;
  logic        rx_empty = 1'b1, rx_data_read = 1'b0, rx_read_last = 1'b0;
  logic        rx_head_valid = 1'b0, rx_head_pmp = 1'b0, rx_next_valid = 1'b0, rx_next_pmp = 1'b0;
  logic [11:0] rx_src_set = 12'h000;
  logic        tx_ready_req, rx_ready_req, tx_event_req, rx_event_req, irq;
  int          failures = 0, samples_checked = 0, cyc = 0;

  always #25 sys_clk = ~sys_clk;

  scirq_top #(.CW(6)) u_scirq_top (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .chan_reset_cmd, .tx_reset_cmd, .rx_reset_cmd, .tx_enable, .tx_count,
    .tx_data_write, .tx_underrun, .tx_idle_enter, .cts_pin_n, .dcd_pin_n, .rx_empty, .rx_data_read,
    .rx_read_last, .rx_head_valid, .rx_head_pmp, .rx_next_valid, .rx_next_pmp, .rx_src_set,
    .crc_result_bad, .tx_ready_req, .rx_ready_req, .tx_event_req, .rx_event_req, .irq);
  scirq_host_model u_scirq_host_model (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  ////////////////////////////////////////////////////////////////
  // shared helpers
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    u_scirq_host_model.acc(1'b1, a, d, rdv);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    u_scirq_host_model.acc(1'b0, a, 32'h0, rdv);
    chk(rdv, e);
  endtask
  // e is {tx event, rx event, tx ready, rx ready}; looked at mid-cycle when settled
  task req(input logic [3:0] e);
    @(negedge sys_clk);
    chk({27'h0, irq, tx_event_req, rx_event_req, tx_ready_req, rx_ready_req}, {27'h0, |e, e});
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rd(OFF_ENABLE_ZERO, 32'h0);
    rd(OFF_STATUS_ZERO, 32'h0);
    rd(6'h3C, 32'h0);
    req(4'h0);
    $display("reset test done");
  endtask
  task t_ready;
    wr(OFF_TX_THRESH, 32'h4);
    wr(OFF_ENABLE_ZERO, 32'h3);
    rd(OFF_ENABLE_ZERO, 32'h3);
    tx_enable <= 1'b1;
    tx_count <= 6'h04;
    rx_empty <= 1'b0;
    tk(2);
    req(4'h3);
    rd(OFF_STATUS_ZERO, 32'h3);
    tx_count <= 6'h05;
    tk(2);
    req(4'h1);
    tx_count <= 6'h04;
    tk(2);
    req(4'h3);
    rx_reset_cmd <= 1'b1;
    tk(1);
    rx_reset_cmd <= 1'b0;
    req(4'h2);
    tx_reset_cmd <= 1'b1;
    tk(1);
    tx_reset_cmd <= 1'b0;
    req(4'h1);
    tx_enable <= 1'b0;
    rx_empty <= 1'b1;
    tk(2);
    req(4'h0);
    $display("ready test done");
  endtask
  task t_tx;
    wr(OFF_TX_EV_EN, 32'h7);
    wr(OFF_ENABLE_ZERO, 32'h0);
    tx_underrun <= 1'b1;
    tk(1);
    tx_underrun <= 1'b0;
    tk(1);
    req(4'h0);
    rd(OFF_STATUS_ZERO, 32'h80);
    wr(OFF_ENABLE_ZERO, 32'h80);
    req(4'h8);
    wr(OFF_TX_EV_EN, 32'h6);
    req(4'h0);
    wr(OFF_TX_EV_STAT, 32'h2);
    rd(OFF_TX_EV_STAT, 32'h1);
    wr(OFF_TX_EV_STAT, 32'h1);
    rd(OFF_TX_EV_STAT, 32'h0);
    tx_idle_enter <= 1'b1;
    tk(1);
    tx_idle_enter <= 1'b0;
    tk(1);
    wr(OFF_TX_EV_STAT, 32'h2);
    rd(OFF_TX_EV_STAT, 32'h2);
    tx_data_write <= 1'b1;
    tk(1);
    tx_data_write <= 1'b0;
    tk(1);
    req(4'h0);
    cts_pin_n <= 1'b0;
    tk(6);
    req(4'h8);
    tx_reset_cmd <= 1'b1;
    tk(1);
    tx_reset_cmd <= 1'b0;
    rd(OFF_TX_EV_STAT, 32'h0);
    $display("tx event test done");
  endtask
  task t_rx;
    wr(OFF_ENABLE_ZERO, 32'h40);
    for (int i = 0; i < 12; i++) begin
      if (i != 1 && i != 10) begin
        wr(OFF_RX_EV_EN, 32'h1 << i);
        rx_src_set <= 12'h1 << i;
        tk(1);
        rx_src_set <= 12'h000;
        tk(1);
        req(4'h4);
        wr(OFF_RX_EV_STAT, 32'h1 << i);
        req(4'h0);
      end
    end
    wr(OFF_RX_EV_EN, 32'h2);
    dcd_pin_n <= 1'b0;
    tk(6);
    req(4'h4);
    rx_src_set <= 12'h9FD;
    tk(1);
    rx_src_set <= 12'h000;
    rx_reset_cmd <= 1'b1;
    tk(1);
    rx_reset_cmd <= 1'b0;
    rd(OFF_RX_EV_STAT, 32'h0);
    $display("rx event test done");
  endtask
  task t_frame;
    wr(OFF_MODE_ZERO, 32'h4);
    rx_src_set <= 12'h090;
    tk(1);
    rx_src_set <= 12'h000;
    rd(OFF_FRAME_LIVE, 32'h09);
    rx_data_read <= 1'b1;
    rx_read_last <= 1'b1;
    tk(1);
    rx_data_read <= 1'b0;
    rx_read_last <= 1'b0;
    rd(OFF_FRAME_SAVED, 32'h09);
    rd(OFF_RX_EV_STAT, 32'h400);
    wr(OFF_RX_EV_STAT, 32'h400);
    wr(OFF_MODE_ZERO, 32'h8);
    crc_result_bad <= 1'b1;
    tk(2);
    rd(OFF_RX_EV_STAT, 32'h200);
    crc_result_bad <= 1'b0;
    tk(2);
    rd(OFF_RX_EV_STAT, 32'h000);
    $display("frame and crc test done");
  endtask
  // rx_data_read pulses are driven by the bench; parity flags clear from the byte flags alone
  task t_pmp;
    for (int m = 1; m >= 0; m--) begin
      wr(OFF_MODE_ZERO, m);
      rx_src_set <= 12'h020;
      rx_next_valid <= 1'b1;
      rx_next_pmp <= (m == 0);
      tk(1);
      rx_src_set <= 12'h000;
      rx_head_valid <= 1'b1;
      rx_data_read <= 1'b1;
      tk(1);
      rx_data_read <= 1'b0;
      tk(2);
      rd(OFF_RX_EV_STAT, m ? 32'h0 : 32'h20);
    end
    rx_next_pmp <= 1'b0;
    tk(3);
    rd(OFF_RX_EV_STAT, 32'h0);
    rx_head_valid <= 1'b0;
    rx_next_valid <= 1'b0;
    $display("parity test done");
  endtask
  task t_chan;
    wr(OFF_ENABLE_ZERO, 32'hC3);
    wr(OFF_TX_THRESH, 32'h7);
    chan_reset_cmd <= 1'b1;
    tk(1);
    chan_reset_cmd <= 1'b0;
    rd(OFF_ENABLE_ZERO, 32'h0);
    rd(OFF_TX_THRESH, 32'h0);
    rd(OFF_RX_EV_STAT, 32'h0);
    $display("channel reset test done");
  endtask
  ////////////////////////////////////////////////////////////////
  // cut a hang short well past the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    tk(12);
    rst_n <= 1'b1;
    t_reset;
    t_ready;
    t_tx;
    t_rx;
    t_frame;
    t_pmp;
    t_chan;
    finish_test;
  end
endmodule
